// file: bench/node_cfg_monitor.sv
// Assertions on the ports of the node register block.
// Bound from the bench top; one clock, synchronous active-high reset.
`timescale 1ns/10ps
module node_cfg_monitor import node_pkg::*; #(
  parameter logic [7:0] DESIGN_VERSION = 8'h5a // Arbitrary value.
) (
  input wire logic       ref_clk_in, reset_in, reg_write_in, reg_read_in,
  input wire logic       step_in, dir_in, csn_pin_in, sck_pin_in, sdi_pin_in,
  input wire logic [6:0] reg_index_in,
  input wire reg_word_t  reg_wdata_in, reg_rdata_out,
  input wire logic       reg_rvalid_out, next_address_output_pol_out,
  input wire node_addr_t node_address_out,
  input wire bit_times_t reply_delay_bits_out
);
  logic [2:0] pn;
  assign pn = {csn_pin_in, sck_pin_in, sdi_pin_in};
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  AST_RVALID: assert property (reg_read_in |=> reg_rvalid_out)
    else $error("read not answered");
  AST_RVALID_CAUSE: assert property (
    reg_rvalid_out |-> $past(reg_read_in)) else $error("answer without read");
  AST_ADDR: assert property (reg_write_in && reg_index_in == 7'h03 ##1
    !reg_write_in && $stable(pn) |=>
    node_address_out == 8'($past(reg_wdata_in[7:0], 2) + $past(pn)))
    else $error("node address wrong");
  AST_DELAY: assert property (reg_write_in && reg_index_in == 7'h03 ##1
    !reg_write_in |=>
    reply_delay_bits_out == {$past(reg_wdata_in[11:9], 2), 4'h8})
    else $error("reply delay wrong");
  AST_POL: assert property (reg_write_in && reg_index_in == 7'h04 ##1
    !reg_write_in |=>
    next_address_output_pol_out == $past(reg_wdata_in[12], 2))
    else $error("polarity not stored");
  AST_POL_RESET: assert property (
    $fell(reset_in) |-> next_address_output_pol_out)
    else $error("polarity reset wrong");
  AST_LEVELS: assert property (reg_read_in && reg_index_in == 7'h04 |=>
    reg_rdata_out[1:0] == $past({dir_in, step_in}) &&
    reg_rdata_out[31:24] == DESIGN_VERSION) else $error("levels word wrong");
  AST_UNMAPPED: assert property (reg_read_in && reg_index_in != 7'h03 &&
    reg_index_in != 7'h04 |=> reg_rdata_out == 32'h0)
    else $error("unmapped read");
endmodule

// file: bench/node_host.sv
// Host model: issues one-cycle register strobes and collects answers.
// Released write data shows its inverse, never the last value.
`timescale 1ns/10ps
module node_host import node_pkg::*; (
  input  wire logic      ref_clk_in, rvalid_in,
  input  wire reg_word_t rdata_in,
  output logic [6:0]     idx_out,
  output logic           wr_out, rd_out,
  output reg_word_t      wdata_out
);
  initial {idx_out, wr_out, rd_out, wdata_out} = '0;
  task automatic wr(input logic [6:0] i, input reg_word_t d);
    @(posedge ref_clk_in) #1;
    {idx_out, wdata_out, wr_out} = {i, d, 1'b1};
    @(posedge ref_clk_in) #1;
    {wdata_out, wr_out} = {~d, 1'b0};
  endtask
  task automatic rd(input logic [6:0] i, output reg_word_t d,
                    output logic ok);
    int n;
    @(posedge ref_clk_in) #1;
    {idx_out, rd_out, ok, d} = {i, 1'b1, 1'b0, 32'h0};
    @(posedge ref_clk_in) #1;
    rd_out = 0;
    for (n = 0; n < 4 && !ok; n++) begin
      if (rvalid_in === 1'b1) {ok, d} = {1'b1, rdata_in};
      else @(posedge ref_clk_in) #1;
    end
  endtask
endmodule

// file: bench/test_uart_node_config_and_pin_status.sv
// Bench for the node register block; the host model drives the strobes.
// Pin levels come from two vectors that the scenarios set.
`timescale 1ns/10ps
module test_uart_node_config_and_pin_status;
  import node_pkg::*;
  localparam logic [7:0] VER = 8'h5a; // Arbitrary version code.
  int err_count = 0, comparisons = 0;
  logic ref_clk_in = 0, reset_in = 1, reg_write_in, reg_read_in;
  logic [6:0] reg_index_in;
  reg_word_t reg_wdata_in, reg_rdata_out;
  logic step_in, dir_in, encoder_b_level_in, encoder_a_level_in;
  logic driver_disable_level_in, encoder_index_level_in, single_wire_serial_in;
  logic chop_comp_a_in, chop_comp_b_in, load_comparator_a_test_in;
  logic load_comparator_b_test_in, reference_resistor_found_in;
  logic outside_oscillator_used_in, adc_fault_in, csn_pin_in, sck_pin_in;
  logic sdi_pin_in, reg_rvalid_out, next_address_output_pol_out;
  logic [2:0] die_revision_in, pn = 0;
  logic [16:0] lv = 0;
  node_addr_t node_address_out;
  bit_times_t reply_delay_bits_out;
  assign {die_revision_in, adc_fault_in, outside_oscillator_used_in,
    reference_resistor_found_in, load_comparator_b_test_in,
    load_comparator_a_test_in, chop_comp_b_in, chop_comp_a_in,
    single_wire_serial_in, encoder_index_level_in, driver_disable_level_in,
    encoder_a_level_in, encoder_b_level_in, dir_in, step_in} = lv;
  assign {csn_pin_in, sck_pin_in, sdi_pin_in} = pn;
  always #10 ref_clk_in = ~ref_clk_in;
  uart_node_config_and_pin_status #(.DESIGN_VERSION(VER)) DUT (.*);
  node_host host (.ref_clk_in, .rvalid_in(reg_rvalid_out),
    .rdata_in(reg_rdata_out), .idx_out(reg_index_in), .wr_out(reg_write_in),
    .rd_out(reg_read_in), .wdata_out(reg_wdata_in));
  task automatic cmp(input string nm, input reg_word_t e, g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic get(input logic [6:0] i, output reg_word_t d);
    logic ok;
    host.rd(i, d, ok);
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected rvalid exp 1 got 0");
      tally_and_finish();
    end
  endtask
  task automatic t_reset;
    reg_word_t d;
    get(7'h03, d); cmp("setup", 32'h0, d);
    get(7'h04, d); cmp("pol", 32'h1000, d & 32'h1000);
  endtask
  task automatic t_levels;
    reg_word_t d;
    for (int i = 0; i < 17; i++) begin
      lv = 17'h1 << i;
      get(7'h04, d);
      cmp("levels", {VER, 5'h0, lv[16:11], 1'b1, lv[10:7], 1'b0,
        lv[6:0]}, d);
    end
    lv = 0;
  endtask
  task automatic t_pol;
    reg_word_t d;
    host.wr(7'h04, 32'hffffefff);
    @(posedge ref_clk_in) #1;
    cmp("pol_out", 32'h0, 32'(next_address_output_pol_out));
    get(7'h04, d); cmp("levels_ro", {VER, 24'h0}, d);
  endtask
  task automatic t_node;
    reg_word_t d;
    for (int k = 0; k < 8; k++) begin
      pn = 3'(k);
      host.wr(7'h03, 32'(k * 512 + 17 * k));
      @(posedge ref_clk_in) #1;
      cmp("delay", 32'(16 * k + 8), 32'(reply_delay_bits_out));
      cmp("addr", 32'(18 * k), 32'(node_address_out));
      get(7'h03, d); cmp("readback", 32'(k * 512 + 17 * k), d);
    end
    host.wr(7'h07, 32'hffffffff);
    get(7'h05, d); cmp("unmapped", 32'h0, d);
    get(7'h03, d); cmp("kept", 32'h0e77, d);
  endtask
  task automatic t_rerun;
    @(posedge ref_clk_in) #1;
    reset_in = 1;
    repeat (2) @(posedge ref_clk_in);
    #1 reset_in = 0;
    @(posedge ref_clk_in) #1;
    cmp("addr_rst", 32'(pn), 32'(node_address_out));
    cmp("delay_rst", 32'h8, 32'(reply_delay_bits_out));
    cmp("rdata_rst", 32'h0, reg_rdata_out);
    t_reset;
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_in);
    #1 reset_in = 0;
    t_reset; t_levels; t_pol; t_node; t_rerun;
    tally_and_finish;
  end
endmodule
bind uart_node_config_and_pin_status node_cfg_monitor #(
  .DESIGN_VERSION(DESIGN_VERSION)) mon (.ref_clk_in, .reset_in, .reg_write_in,
  .reg_read_in, .step_in, .dir_in, .csn_pin_in, .sck_pin_in, .sdi_pin_in,
  .reg_index_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out,
  .next_address_output_pol_out, .node_address_out, .reply_delay_bits_out);

// file: verilog/node_defines.svh
// Offsets, field positions and reset values of the node registers.
// Included by the node register module; holds definitions only.
`ifndef NODE_DEFINES_SVH
`define NODE_DEFINES_SVH

`define SETUP_OFFSET      7'h03
`define LEVELS_OFFSET     7'h04

`define GAP_MSB           11
`define GAP_LSB           8
`define BASE_MSB          7
`define BASE_LSB          0

`define LVL_STEP          0
`define LVL_DIR           1
`define LVL_ENC_B         2
`define LVL_ENC_A         3
`define LVL_DRV_DIS       4
`define LVL_ENC_N         5
`define LVL_SERIAL        6
`define LVL_CHOP_A        8
`define LVL_CHOP_B        9
`define LVL_LOAD_A        10
`define LVL_LOAD_B        11
`define LVL_POLARITY      12
`define LVL_REF_RES       13
`define LVL_OUT_OSC       14
`define LVL_ADC_ERR       15
`define REV_MSB           18
`define REV_LSB           16
`define VER_MSB           31
`define VER_LSB           24

`define GAP_RESET         4'h0
`define BASE_RESET        8'h00
`define POLARITY_RESET    1'b1
// Gap code zero gives eight bit times.
`define DELAY_RESET       7'h08

`endif

// file: verilog/node_pkg.sv
// Types shared by the node register module and its bench.
// Assumes nothing of its surroundings.
package node_pkg;
  typedef logic [3:0]  reply_gap_t;
  typedef logic [7:0]  node_addr_t;
  typedef logic [31:0] reg_word_t;
  typedef logic [6:0]  bit_times_t;
endpackage

// file: verilog/uart_node_config_and_pin_status.sv
// Node configuration and input level registers of a serial stepper node.
// Assumes a framing layer that issues one-cycle read and write strobes
// with a register index, all synchronous to ref_clk_in.
//
// How it works
// - Even gap code sets (code+1)*8 bit delay.
// - Base node address stored, readable, reset zero.
// - Effective address is base plus pin offset.
// - Input pin levels read back at bits 5:0.
// - Version byte and die revision read only.
// - Writable polarity bit twelve, resets to one.
// - Bit six shows serial mode pin selection.
// - Bit fifteen flags faulty converter.
// - Bit fourteen flags outside oscillator used.
`timescale 1ns/10ps
`include "node_defines.svh"

module uart_node_config_and_pin_status #(
  parameter int                 ADDR_W         = 7,
  parameter logic [7:0]         DESIGN_VERSION = 8'h5a // Arbitrary value.
) (
  input  wire logic             ref_clk_in,
  input  wire logic             reset_in,
  input  wire logic [ADDR_W-1:0] reg_index_in,
  input  wire logic             reg_write_in,
  input  wire logic             reg_read_in,
  input  wire node_pkg::reg_word_t reg_wdata_in,
  input  wire logic             step_in,
  input  wire logic             dir_in,
  input  wire logic             encoder_b_level_in,
  input  wire logic             encoder_a_level_in,
  input  wire logic             driver_disable_level_in,
  input  wire logic             encoder_index_level_in,
  input  wire logic             single_wire_serial_in,
  input  wire logic             chop_comp_a_in,
  input  wire logic             chop_comp_b_in,
  input  wire logic             load_comparator_a_test_in,
  input  wire logic             load_comparator_b_test_in,
  input  wire logic             reference_resistor_found_in,
  input  wire logic             outside_oscillator_used_in,
  input  wire logic             adc_fault_in,
  input  wire logic [2:0]       die_revision_in,
  input  wire logic             csn_pin_in,
  input  wire logic             sck_pin_in,
  input  wire logic             sdi_pin_in,
  output logic                  reg_rvalid_out,
  output node_pkg::reg_word_t   reg_rdata_out,
  output node_pkg::node_addr_t  node_address_out,
  output node_pkg::bit_times_t  reply_delay_bits_out,
  output logic                  next_address_output_pol_out
);
  import node_pkg::*;

  // ************************************************************
  // Configuration state
  // ************************************************************
  // Written only through the register strobes.
  reply_gap_t reply_gap_code_ff;
  reply_gap_t nxt_reply_gap_code;
  node_addr_t base_node_address_ff;
  node_addr_t nxt_base_node_address;
  logic       polarity_ff;
  logic       nxt_polarity;

  // ************************************************************
  // Read answer state
  // ************************************************************
  // One answer word per read strobe, held until the next read.
  logic       rvalid_ff;
  logic       nxt_rvalid;
  reg_word_t  rdata_ff;
  reg_word_t  nxt_rdata;

  // ************************************************************
  // Derived line values
  // ************************************************************
  // Registered so that the framing layer sees no adder path.
  node_addr_t node_address_ff;
  node_addr_t nxt_node_address;
  bit_times_t delay_bits_ff;
  bit_times_t nxt_delay_bits;

  // ************************************************************
  // Helpers
  // ************************************************************
  reg_word_t  levels_word;
  reg_word_t  setup_word;
  logic [2:0] pin_offset;
  logic       setup_write;
  logic       levels_write;

  // True when a strobe index names the register at the given offset.
  function automatic logic index_hit(input logic [ADDR_W-1:0] idx,
                                     input logic [6:0]        offs);
    index_hit = (idx == offs[ADDR_W-1:0]);
  endfunction

  // Folds a gap code onto its even value and scales it to bit times.
  // An odd code would otherwise give a delay the host never asked for.
  function automatic bit_times_t gap_to_bits(input reply_gap_t code);
    gap_to_bits = {code[3:1], 1'b1, 3'h0};
  endfunction

  // ************************************************************
  // Strobe decode and pin offset
  // ************************************************************
  always_comb begin
    setup_write  = reg_write_in && index_hit(reg_index_in, `SETUP_OFFSET);
    levels_write = reg_write_in && index_hit(reg_index_in, `LEVELS_OFFSET);
    // Offset pins are chip select, clock and serial in, high to low.
    pin_offset   = {csn_pin_in, sck_pin_in, sdi_pin_in};
  end

  // ************************************************************
  // Readback words
  // ************************************************************
  always_comb begin
    setup_word                      = '0;
    setup_word[`GAP_MSB:`GAP_LSB]   = reply_gap_code_ff;
    setup_word[`BASE_MSB:`BASE_LSB] = base_node_address_ff;
  end

  // Pins are taken as synchronous to the clock, so they go straight in.
  always_comb begin
    levels_word                        = '0;
    levels_word[`LVL_STEP]             = step_in;
    levels_word[`LVL_DIR]              = dir_in;
    levels_word[`LVL_ENC_B]            = encoder_b_level_in;
    levels_word[`LVL_ENC_A]            = encoder_a_level_in;
    levels_word[`LVL_DRV_DIS]          = driver_disable_level_in;
    levels_word[`LVL_ENC_N]            = encoder_index_level_in;
    levels_word[`LVL_SERIAL]           = single_wire_serial_in;
    levels_word[`LVL_CHOP_A]           = chop_comp_a_in;
    levels_word[`LVL_CHOP_B]           = chop_comp_b_in;
    levels_word[`LVL_LOAD_A]           = load_comparator_a_test_in;
    levels_word[`LVL_LOAD_B]           = load_comparator_b_test_in;
    levels_word[`LVL_POLARITY]         = polarity_ff;
    levels_word[`LVL_REF_RES]          = reference_resistor_found_in;
    levels_word[`LVL_OUT_OSC]          = outside_oscillator_used_in;
    levels_word[`LVL_ADC_ERR]          = adc_fault_in;
    levels_word[`REV_MSB:`REV_LSB]     = die_revision_in;
    levels_word[`VER_MSB:`VER_LSB]     = DESIGN_VERSION;
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_comb begin
    nxt_reply_gap_code    = reply_gap_code_ff;
    nxt_base_node_address = base_node_address_ff;
    nxt_polarity          = polarity_ff;
    if (setup_write) begin
      // Bits 31:12 of the setup word are dropped and read back as zero.
      nxt_reply_gap_code    = reg_wdata_in[`GAP_MSB:`GAP_LSB];
      nxt_base_node_address = reg_wdata_in[`BASE_MSB:`BASE_LSB];
    end
    if (levels_write) begin
      // Only the polarity bit of the level word is writable.
      nxt_polarity = reg_wdata_in[`LVL_POLARITY];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      reply_gap_code_ff    <= `GAP_RESET;
      base_node_address_ff <= `BASE_RESET;
      polarity_ff          <= `POLARITY_RESET;
    end else begin
      reply_gap_code_ff    <= nxt_reply_gap_code;
      base_node_address_ff <= nxt_base_node_address;
      polarity_ff          <= nxt_polarity;
    end
  end

  // ************************************************************
  // Read answer registers
  // ************************************************************
  always_comb begin
    nxt_rvalid = reg_read_in;
    nxt_rdata  = rdata_ff;
    // A read alongside a write sees the contents before the write.
    if (reg_read_in) begin
      if (index_hit(reg_index_in, `SETUP_OFFSET)) begin
        nxt_rdata = setup_word;
      end else if (index_hit(reg_index_in, `LEVELS_OFFSET)) begin
        nxt_rdata = levels_word;
      end else begin
        // Unmapped indices answer with an all-zero word.
        nxt_rdata = '0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
    end
  end

  // ************************************************************
  // Derived line value registers
  // ************************************************************
  always_comb begin
    // Sum wraps at 8 bits; staying at or below 254 is up to the host.
    nxt_node_address = 8'(base_node_address_ff
                          + {5'h00, pin_offset});
    // Odd codes fold onto the even code below them.
    nxt_delay_bits   = gap_to_bits(reply_gap_code_ff);
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      node_address_ff <= `BASE_RESET;
      delay_bits_ff   <= `DELAY_RESET;
    end else begin
      node_address_ff <= nxt_node_address;
      delay_bits_ff   <= nxt_delay_bits;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Every output is a plain copy of a flip-flop.
  assign reg_rvalid_out              = rvalid_ff;
  assign reg_rdata_out               = rdata_ff;
  assign node_address_out            = node_address_ff;
  assign reply_delay_bits_out        = delay_bits_ff;
  assign next_address_output_pol_out = polarity_ff;

endmodule
